// [hw/sfar_top.sv]
// Address-mode, bank register, soft reset and parameter-table command slice
// Overview of operation
// - Bank register bit 7 set means 4-byte addressing; upper bits then ignored.
// - Bit 7 clear means 3-byte addressing with bits 6:0 giving A[30:24].
// - Instruction 16h reads back the bank register.
// - Instruction 17h plus exactly one data byte loads the bank register.
// - Instruction E9h leaves 4-byte mode without needing write enable.
// - Soft reset happens only when 66h is directly followed by 99h.
// - The reset pair is accepted on 1, 2 or 4 lines per mode.
// - Instruction 50h sets the volatile select until the next instruction byte is decoded.
// - Hardware reset, soft reset or power cycle leave 4-byte mode.
// - Dedicated instructions always use 4-byte addresses whatever the mode.
// - Parameter table returns F8h, A1h, FBh at bytes 3Eh, 3Fh, 40h.
// - Instruction B7h enters 4-byte mode without needing write enable.
`timescale 1ns/1ns
`include "sfar_cfg.svh"

module sfar_top
  import sfar_pkg::*;
(
  // Clock and power-on reset
  input  wire logic       core_clk_i,
  input  wire logic       rst_n_i,
  // Serial link pins
  input  wire logic       sck_i,
  input  wire logic       cs_n_i,
  input  wire logic       hw_rst_n_i,
  input  wire logic [3:0] io_i,
  output logic      [3:0] io_o,
  output logic      [3:0] io_oe_o,
  // Operating mode from the rest of the device
  input  wire logic [1:0] io_mode_i,
  // To the array access logic
  output logic            cmd_valid_o,
  output logic      [7:0] cmd_byte_o,
  output logic            addr_4byte_o,
  output logic      [6:0] addr_hi_o,
  output logic      [7:0] bank_o,
  output logic            vol_sr_sel_o,
  output logic            soft_rst_o
);

  sfar_state_t r;
  sfar_state_t n;
  logic        rise;
  logic        fall;
  logic [3:0]  lanes;
  logic [7:0]  nb;
  logic        byte_done;

  initial
  begin
    if ($bits(io_i) != 4)
      $error("sfar_top needs four data lines");
  end

  function automatic logic [7:0] shin(input logic [7:0] s, input logic [3:0] d,
                                      input logic [1:0] m);
    case (m)
      `SFAR_MODE_QUAD: shin = {s[3:0], d};
      `SFAR_MODE_DUAL: shin = {s[5:0], d[1:0]};
      default:         shin = {s[6:0], d[0]};
    endcase
  endfunction

  function automatic logic [7:0] lut(input logic [7:0] a);
    case (a)
      `SFAR_SFDP_OFF_A: lut = `SFAR_SFDP_VAL_A;
      `SFAR_SFDP_OFF_B: lut = `SFAR_SFDP_VAL_B;
      `SFAR_SFDP_OFF_C: lut = `SFAR_SFDP_VAL_C;
      default:          lut = `SFAR_SFDP_BLANK;
    endcase
  endfunction

  function automatic logic is_ded4(input logic [7:0] c);
    is_ded4 = (c == `SFAR_CMD_4B_READ) || (c == `SFAR_CMD_4B_PP) ||
              (c == `SFAR_CMD_4B_QIOR) || (c == `SFAR_CMD_4B_QDDR) ||
              (c == `SFAR_CMD_4B_SE) || (c == `SFAR_CMD_4B_BE);
  endfunction

  // Link clock is only sampled; edges come from the synchronised copy
  assign rise  = r.sync2.sck & ~r.sck_d;
  assign fall  = ~r.sync2.sck & r.sck_d;
  // Lane count follows the current interface width, for every instruction
  assign lanes = (io_mode_i == `SFAR_MODE_QUAD) ? 4'h4 :
                 (io_mode_i == `SFAR_MODE_DUAL) ? 4'h2 : 4'h1;
  assign nb    = shin(r.sh, r.sync2.io, io_mode_i);
  assign byte_done = rise && ((r.cnt + lanes) == `SFAR_BYTE_BITS) &&
                     (r.phase inside {SFAR_CMD, SFAR_ADDR, SFAR_DIN});

  always_comb
  begin
    n           = r;
    n.sync1     = '{sck: sck_i, cs_n: cs_n_i, hw_rst_n: hw_rst_n_i, io: io_i};
    n.sync2     = r.sync1;
    n.sck_d     = r.sync2.sck;
    n.cmd_pulse = 1'b0;
    n.soft_rst  = 1'b0;
    if (!r.sync2.hw_rst_n)
    begin
      n.ext       = `SFAR_EXT_RESET;
      n.rst_armed = 1'b0;
      n.vol_sr    = 1'b0;
      n.ded4      = 1'b0;
      n.phase     = SFAR_CMD;
      n.cnt       = 4'h0;
      n.io_oe     = 4'h0;
    end
    else if (r.sync2.cs_n)
    begin
      n.phase = SFAR_CMD;
      n.cnt   = 4'h0;
      n.bcnt  = 2'h0;
      n.io_oe = 4'h0;
    end
    else
    begin
      if (rise && (r.phase inside {SFAR_CMD, SFAR_ADDR, SFAR_DIN}))
      begin
        n.sh  = nb;
        n.cnt = byte_done ? 4'h0 : r.cnt + lanes;
      end
      case (r.phase)
        SFAR_CMD:
        begin
          if (byte_done)
          begin
            n.cmd       = nb;
            n.phase     = SFAR_DONE;
            // Any instruction other than 66h disarms the reset pair
            n.rst_armed = (nb == `SFAR_CMD_RST_EN);
            // Volatile selection ends when the next instruction byte after 50h is decoded
            n.vol_sr    = (nb == `SFAR_CMD_VOL_SR);
            n.ded4      = is_ded4(nb);
            case (nb)
              `SFAR_CMD_RD_EXT:
              begin
                n.out   = r.ext;
                n.phase = SFAR_DOUT;
              end
              `SFAR_CMD_WR_EXT: n.phase = SFAR_DIN;
              `SFAR_CMD_EXIT4:  n.ext[`SFAR_EXT_4B_BIT] = 1'b0;
              `SFAR_CMD_ENTER4: n.ext[`SFAR_EXT_4B_BIT] = 1'b1;
              `SFAR_CMD_SFDP:   n.phase = SFAR_ADDR;
              `SFAR_CMD_RST:
              begin
                if (r.rst_armed)
                begin
                  n.ext      = `SFAR_EXT_RESET;
                  n.vol_sr   = 1'b0;
                  n.ded4     = 1'b0;
                  n.soft_rst = 1'b1;
                end
              end
              `SFAR_CMD_RST_EN, `SFAR_CMD_VOL_SR, `SFAR_CMD_WREN: ;
              default: n.cmd_pulse = 1'b1;
            endcase
          end
        end
        SFAR_ADDR:
        begin
          if (byte_done)
          begin
            n.sfdp_addr = nb;
            n.bcnt      = r.bcnt + 2'h1;
            if (r.bcnt == `SFAR_SFDP_ADDR_LST)
              n.phase = SFAR_DUMMY;
          end
        end
        SFAR_DUMMY:
        begin
          if (rise)
          begin
            n.cnt = r.cnt + 4'h1;
            if (r.cnt == (`SFAR_SFDP_DUMMY - 4'h1))
            begin
              n.cnt   = 4'h0;
              n.out   = lut(r.sfdp_addr);
              n.phase = SFAR_DOUT;
            end
          end
        end
        SFAR_DIN:
        begin
          if (byte_done)
          begin
            n.ext   = nb;
            n.phase = SFAR_DONE;
          end
        end
        SFAR_DOUT:
        begin
          if (fall)
          begin
            case (io_mode_i)
              `SFAR_MODE_QUAD:
              begin
                n.io_out = r.out[7:4];
                n.io_oe  = 4'hF;
                n.out    = {r.out[3:0], 4'h0};
              end
              `SFAR_MODE_DUAL:
              begin
                n.io_out = {2'h0, r.out[7:6]};
                n.io_oe  = 4'h3;
                n.out    = {r.out[5:0], 2'h0};
              end
              default:
              begin
                n.io_out = {2'h0, r.out[7], 1'h0};
                n.io_oe  = 4'h2;
                n.out    = {r.out[6:0], 1'h0};
              end
            endcase
            n.cnt = r.cnt + lanes;
            if ((r.cnt + lanes) == `SFAR_BYTE_BITS)
            begin
              // Bank read repeats; table read walks forward
              n.cnt       = 4'h0;
              n.sfdp_addr = r.sfdp_addr + 8'h01;
              n.out       = (r.cmd == `SFAR_CMD_RD_EXT) ? r.ext :
                            lut(r.sfdp_addr + 8'h01);
            end
          end
        end
        SFAR_DONE: ;
        default: n.phase = SFAR_CMD;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      r       <= '0;
      r.phase <= SFAR_CMD;
      r.ext   <= `SFAR_EXT_RESET;
      r.sync1 <= '{sck: 1'b0, cs_n: 1'b1, hw_rst_n: 1'b1, io: 4'h0};
      r.sync2 <= '{sck: 1'b0, cs_n: 1'b1, hw_rst_n: 1'b1, io: 4'h0};
    end
    else
      r <= n;
  end

  assign io_o         = r.io_out;
  assign io_oe_o      = r.io_oe;
  assign cmd_valid_o  = r.cmd_pulse;
  assign cmd_byte_o   = r.cmd;
  assign addr_4byte_o = r.ext[`SFAR_EXT_4B_BIT] | r.ded4;
  assign addr_hi_o    = r.ext[`SFAR_EXT_4B_BIT] ? 7'h00 : r.ext[6:0];
  assign bank_o       = r.ext;
  assign vol_sr_sel_o = r.vol_sr;
  assign soft_rst_o   = r.soft_rst;

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  enter_four_a: assert property (
    byte_done && r.phase == SFAR_CMD && nb == `SFAR_CMD_ENTER4
    && r.sync2.hw_rst_n && !r.sync2.cs_n |=> addr_4byte_o && addr_hi_o == 7'h00)
    else $error("enter 4-byte did not take effect");
  exit_four_a: assert property (
    byte_done && r.phase == SFAR_CMD && nb == `SFAR_CMD_EXIT4
    && r.sync2.hw_rst_n && !r.sync2.cs_n |=> !bank_o[`SFAR_EXT_4B_BIT])
    else $error("exit 4-byte did not take effect");
  bank_write_a: assert property (
    byte_done && r.phase == SFAR_DIN && r.sync2.hw_rst_n && !r.sync2.cs_n
    |=> bank_o == $past(nb) && r.phase == SFAR_DONE)
    else $error("bank write lost or not single byte");
  bank_read_a: assert property (
    byte_done && r.phase == SFAR_CMD && nb == `SFAR_CMD_RD_EXT
    && r.sync2.hw_rst_n && !r.sync2.cs_n |=> r.out == $past(bank_o))
    else $error("bank read loaded wrong byte");
  reset_order_a: assert property (
    soft_rst_o
    |-> $past(r.rst_armed) && cmd_byte_o == `SFAR_CMD_RST)
    else $error("soft reset without enable");
  reset_fire_a: assert property (
    byte_done && r.phase == SFAR_CMD && nb == `SFAR_CMD_RST && r.rst_armed
    && r.sync2.hw_rst_n && !r.sync2.cs_n |=> soft_rst_o)
    else $error("armed soft reset did not fire");
  reset_clear_a: assert property (
    soft_rst_o
    |-> bank_o == `SFAR_EXT_RESET && !addr_4byte_o)
    else $error("soft reset left bank set");
  hw_reset_a: assert property (
    !r.sync2.hw_rst_n
    |=> bank_o == `SFAR_EXT_RESET && !addr_4byte_o)
    else $error("hardware reset left bank set");
  upper_bits_a: assert property (
    !bank_o[`SFAR_EXT_4B_BIT]
    |-> addr_hi_o == bank_o[6:0] && addr_4byte_o == r.ded4)
    else $error("3-byte upper bits wrong");
  table_byte_a: assert property (
    rise && r.phase == SFAR_DUMMY && r.sync2.hw_rst_n && !r.sync2.cs_n
    && r.cnt == (`SFAR_SFDP_DUMMY - 4'h1) && r.sfdp_addr == `SFAR_SFDP_OFF_A
    |=> r.phase == SFAR_DOUT && r.out == `SFAR_SFDP_VAL_A)
    else $error("table byte wrong");
  table_walk_a: assert property (
    fall && r.phase == SFAR_DOUT && r.sync2.hw_rst_n && !r.sync2.cs_n
    && r.cmd == `SFAR_CMD_SFDP && (r.cnt + lanes) == `SFAR_BYTE_BITS
    && r.sfdp_addr == `SFAR_SFDP_OFF_A |=> r.out == `SFAR_SFDP_VAL_B)
    else $error("table walk byte wrong");
  vol_status_a: assert property (
    byte_done && r.phase == SFAR_CMD && r.sync2.hw_rst_n && !r.sync2.cs_n
    |=> vol_sr_sel_o == ($past(nb) == `SFAR_CMD_VOL_SR))
    else $error("volatile status select wrong");

endmodule

// [hw/sfar_cfg.svh]
// Command codes, table bytes and field positions for the address and reset slice
`ifndef SFAR_CFG_SVH
`define SFAR_CFG_SVH
`define SFAR_CMD_RD_EXT    8'h16
`define SFAR_CMD_WR_EXT    8'h17
`define SFAR_CMD_EXIT4     8'hE9
`define SFAR_CMD_ENTER4    8'hB7
`define SFAR_CMD_RST_EN    8'h66
`define SFAR_CMD_RST       8'h99
`define SFAR_CMD_VOL_SR    8'h50
`define SFAR_CMD_WREN      8'h06
`define SFAR_CMD_SFDP      8'h5A
`define SFAR_CMD_4B_READ   8'h13
`define SFAR_CMD_4B_PP     8'h12
`define SFAR_CMD_4B_QIOR   8'hEC
`define SFAR_CMD_4B_QDDR   8'hEE
`define SFAR_CMD_4B_SE     8'h21
`define SFAR_CMD_4B_BE     8'hDC
`define SFAR_SFDP_OFF_A    8'h3E
`define SFAR_SFDP_OFF_B    8'h3F
`define SFAR_SFDP_OFF_C    8'h40
`define SFAR_SFDP_VAL_A    8'hF8
`define SFAR_SFDP_VAL_B    8'hA1
`define SFAR_SFDP_VAL_C    8'hFB
`define SFAR_SFDP_BLANK    8'hFF
`define SFAR_EXT_RESET     8'h00
`define SFAR_EXT_4B_BIT    7
`define SFAR_MODE_SINGLE   2'h0
`define SFAR_MODE_DUAL     2'h1
`define SFAR_MODE_QUAD     2'h2
`define SFAR_BYTE_BITS     4'h8
`define SFAR_SFDP_DUMMY    4'h8
`define SFAR_SFDP_ADDR_LST 2'h2
`endif

// [hw/sfar_pkg.sv]
// Types shared by the address-mode and reset slice
package sfar_pkg;
  typedef struct packed {
    logic       sck;
    logic       cs_n;
    logic       hw_rst_n;
    logic [3:0] io;
  } sfar_pins_t;

  typedef enum logic [2:0] {
    SFAR_CMD   = 3'h0,
    SFAR_ADDR  = 3'h1,
    SFAR_DUMMY = 3'h2,
    SFAR_DIN   = 3'h3,
    SFAR_DOUT  = 3'h4,
    SFAR_DONE  = 3'h5
  } sfar_phase_t;

  typedef struct packed {
    sfar_pins_t  sync1;
    sfar_pins_t  sync2;
    logic        sck_d;
    sfar_phase_t phase;
    logic [7:0]  sh;
    logic [3:0]  cnt;
    logic [1:0]  bcnt;
    logic [7:0]  cmd;
    logic [7:0]  ext;
    logic        rst_armed;
    logic        vol_sr;
    logic        ded4;
    logic [7:0]  sfdp_addr;
    logic [7:0]  out;
    logic [3:0]  io_out;
    logic [3:0]  io_oe;
    logic        cmd_pulse;
    logic        soft_rst;
  } sfar_state_t;
endpackage

// [test/sfar_host_model.sv]
// Host-side link master model for the address and reset slice
`timescale 1ns/1ns
module sfar_host_model (
  // Clock and lane width
  input  wire logic       clk_i,
  input  wire logic [1:0] mode_i,
  // Device lanes and host pins
  input  wire logic [3:0] dev_io_i,
  input  wire logic [3:0] dev_oe_i,
  output logic            sck_o,
  output logic            cs_n_o,
  output logic      [3:0] io_o
);
  logic [3:0] drv = 4'h0;

  assign io_o = (dev_oe_i & dev_io_i) | (~dev_oe_i & drv);
  initial sck_o = 1'b0;
  initial cs_n_o = 1'b1;

  // Ten core clocks a half period: 80 ns link clock
  task automatic half();
    repeat (10) @(negedge clk_i);
  endtask

  task automatic send(input logic [7:0] b);
    int w;
    w = (mode_i == 2'h2) ? 4 : (mode_i == 2'h1) ? 2 : 1;
    for (int i = 8 - w; i >= 0; i -= w)
    begin
      // Idle lanes toggle so a stale level is never mistaken for data
      drv = ~drv;
      for (int k = 0; k < w; k++) drv[k] = b[i + k];
      half();
      sck_o = 1'b1;
      half();
      sck_o = 1'b0;
    end
  endtask

  task automatic recv(output logic [7:0] b);
    for (int i = 0; i < 8; i++)
    begin
      drv = ~drv;
      half();
      sck_o = 1'b1;
      b = {b[6:0], io_o[1]};
      half();
      sck_o = 1'b0;
    end
  endtask

  task automatic end_cs();
    half();
    cs_n_o = 1'b1;
    drv = ~drv;
    half();
  endtask

  task automatic frame(input logic [7:0] tx[$], input int nrd,
                       output logic [7:0] rx[$], input bit keep);
    logic [7:0] b;
    rx = {};
    cs_n_o = 1'b0;
    half();
    foreach (tx[i]) send(tx[i]);
    repeat (nrd)
    begin
      recv(b);
      rx.push_back(b);
    end
    if (!keep) end_cs();
  endtask
endmodule

// [test/tb_top.sv]
// Self-checking bench for the address-mode and reset slice
`timescale 1ns/1ns
`include "sfar_cfg.svh"
module tb_top;
  import sfar_pkg::*;
  logic        core_clk_i = 1'b0;
  logic        rst_n_i    = 1'b0;
  logic        hw_rst_n   = 1'b1;
  logic [1:0]  mode       = 2'h0;
  logic        sck;
  logic        cs_n;
  logic [3:0]  io;
  logic [3:0]  io_o;
  logic [3:0]  io_oe;
  logic        cmd_valid;
  logic [7:0]  cmd_byte;
  logic        a4;
  logic [6:0]  hi;
  logic [7:0]  bank_o;
  logic        vol_sr;
  logic        soft_rst;
  logic [7:0]  bank = 8'h00;
  logic [7:0]  rx[$];
  logic [31:0] seed = 32'hef8e_541d;
  int          soft_seen = 0;
  int          soft_exp  = 0;
  int          valid_seen = 0;
  int          num_errors = 0;
  int          cmp_count  = 0;

  always #2 core_clk_i = ~core_clk_i;
  // Pulses are counted at the falling edge, where they have settled
  always @(negedge core_clk_i)
  begin
    if (soft_rst === 1'b1) soft_seen++;
    if (cmd_valid === 1'b1) valid_seen++;
  end

  sfar_host_model u_host (.clk_i(core_clk_i), .mode_i(mode), .dev_io_i(io_o),
    .dev_oe_i(io_oe), .sck_o(sck), .cs_n_o(cs_n), .io_o(io));

  sfar_top u_dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .sck_i(sck),
    .cs_n_i(cs_n), .hw_rst_n_i(hw_rst_n), .io_i(io), .io_o(io_o),
    .io_oe_o(io_oe), .io_mode_i(mode), .cmd_valid_o(cmd_valid),
    .cmd_byte_o(cmd_byte), .addr_4byte_o(a4), .addr_hi_o(hi), .bank_o(bank_o),
    .vol_sr_sel_o(vol_sr), .soft_rst_o(soft_rst));

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Bank value and the address outputs it implies
  task automatic st();
    chk("bank", bank, bank_o);
    chk("addr_4byte", {7'h0, bank[7]}, {7'h0, a4});
    chk("addr_hi", bank[7] ? 8'h00 : {1'b0, bank[6:0]}, {1'b0, hi});
  endtask

  task automatic cmd(input logic [7:0] c);
    u_host.frame('{c}, 0, rx, 0);
  endtask

  task automatic tally_and_finish();
    $display("compares %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    #100000;
    num_errors++;
    tally_and_finish();
  end

  initial
  begin
    repeat (8) @(negedge core_clk_i);
    rst_n_i = 1'b1;
    repeat (6) @(negedge core_clk_i);
    st();
    for (int n = 0; n < 4; n++)
    begin
      bank = 8'(xs());
      u_host.frame('{`SFAR_CMD_WR_EXT, bank}, 0, rx, 0);
      st();
      u_host.frame('{`SFAR_CMD_RD_EXT}, 1, rx, 0);
      chk("read_ext", bank, rx[0]);
      chk("io_oe_idle", 8'h00, {4'h0, io_oe});
    end
    bank[7] = 1'b0;
    u_host.frame('{`SFAR_CMD_WR_EXT, bank}, 0, rx, 0);
    cmd(`SFAR_CMD_ENTER4);
    bank[7] = 1'b1;
    st();
    cmd(`SFAR_CMD_EXIT4);
    bank[7] = 1'b0;
    st();
    for (int m = 0; m < 3; m++)
    begin
      mode = m[1:0];
      cmd(`SFAR_CMD_ENTER4);
      cmd(`SFAR_CMD_RST_EN);
      cmd(`SFAR_CMD_RST);
      bank = 8'h00;
      soft_exp++;
      st();
      chk("soft_rst", soft_exp[7:0], soft_seen[7:0]);
    end
    mode = 2'h0;
    cmd(`SFAR_CMD_ENTER4);
    cmd(`SFAR_CMD_RST_EN);
    cmd(`SFAR_CMD_WREN);
    cmd(`SFAR_CMD_RST);
    bank[7] = 1'b1;
    st();
    chk("soft_rst", soft_exp[7:0], soft_seen[7:0]);
    hw_rst_n = 1'b0;
    repeat (8) @(negedge core_clk_i);
    hw_rst_n = 1'b1;
    repeat (6) @(negedge core_clk_i);
    bank = 8'h00;
    st();
    cmd(`SFAR_CMD_VOL_SR);
    chk("vol_sr", 8'h01, {7'h0, vol_sr});
    u_host.frame('{`SFAR_CMD_4B_READ}, 0, rx, 1);
    repeat (6) @(negedge core_clk_i);
    chk("addr_4byte_ded", 8'h01, {7'h0, a4});
    chk("vol_sr", 8'h00, {7'h0, vol_sr});
    chk("cmd_valid", 8'h01, valid_seen[7:0]);
    chk("cmd_byte", `SFAR_CMD_4B_READ, cmd_byte);
    u_host.end_cs();
    u_host.frame('{`SFAR_CMD_SFDP, 8'h00, 8'h00, `SFAR_SFDP_OFF_A, 8'h00}, 3, rx, 0);
    chk("table_3e", 8'hf8, rx[0]);
    chk("table_3f", 8'ha1, rx[1]);
    chk("table_40", 8'hfb, rx[2]);
    tally_and_finish();
  end
endmodule
